//--- src/break_condition_match_flags.sv
// break condition match and sequential flags with an axi4-lite status slave
// Overview of operation
// - first channel flag set once matched
// - first channel reports condition six
// - second channel flag set once matched
// - second channel reports condition five
// - four flags for conditions one to four
// - sequential flag: first matched, second not
// - channels map to conditions six, five
// - chain flag: four matched, three not
// - chain flag sets again on re-match
// - break occurrence clears match flags
// - channel flags hold until cleared
module break_condition_match_flags
(
  input  wire logic        clk_i,          // processor clock
  input  wire logic        nrst_i,         // async reset, active low
  // comparator events, same clock domain, one-cycle pulses
  input  wire logic        chan_a_hit_i,   // user_break_unit first channel hit
  input  wire logic        chan_b_hit_i,   // user_break_unit second channel hit
  input  wire logic [3:0]  cond_hit_i,     // conditions one (bit0) to four (bit3)
  input  wire logic        break_taken_i,  // a break has actually occurred
  // status towards the debug link
  output logic [5:0]       match_o,        // match flags, registered
  output logic [1:0]       seq_o,          // sequential flags, registered
  output logic             irq_o,          // level interrupt
  // axi4-lite slave
  input  wire logic [7:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  input  wire logic [7:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i
);

  // ==========================================================================
  // state declarations
  break_flags_pkg::match_flags_s match_q;     // sticky match flags
  break_flags_pkg::match_flags_s match_d;     // next match flags
  break_flags_pkg::match_flags_s hit;         // this cycle's hits in flag layout
  break_flags_pkg::seq_flags_s   seq_q;       // sequential flags
  logic [break_flags_pkg::CTRL_WIDTH-1:0] ctrl_q; // mode control
  logic [break_flags_pkg::EVT_WIDTH-1:0]  stat_q; // sticky events
  logic [break_flags_pkg::EVT_WIDTH-1:0]  mask_q; // event enables
  logic [break_flags_pkg::EVT_WIDTH-1:0]  evt;    // event pulses this cycle
  logic [break_flags_pkg::EVT_WIDTH-1:0]  w1c;    // bits software clears

  // write channel holding
  logic        aw_got_q;   // write address taken
  logic        w_got_q;    // write data taken
  logic [7:0]  awaddr_q;   // latched write address
  logic [31:0] wdata_q;    // latched write data
  logic [3:0]  wstrb_q;    // latched byte strobes
  logic        bvalid_q;   // write response pending
  logic [1:0]  bresp_q;    // write response code
  logic        wr_fire;    // both halves present, perform write

  // read channel
  logic        rvalid_q;   // read data pending
  logic [31:0] rdata_q;    // read data
  logic [1:0]  rresp_q;    // read response code
  logic [31:0] rd_val;     // decoded read value
  logic        rd_hit;     // read address is mapped

  // mode decode
  logic ubu_as_cond;       // channels act as conditions five and six
  logic ubu_seq;           // user break unit sequential mode
  logic chain4;            // four-stage chain selected

  assign ubu_as_cond = ctrl_q[break_flags_pkg::UBU_AS_COND_BIT];
  assign ubu_seq     = ctrl_q[break_flags_pkg::UBU_SEQ_BIT];
  assign chain4      = ctrl_q[break_flags_pkg::CHAIN4_BIT];

  // ==========================================================================
  // match flags
  // hits gathered in the flag layout; the channel bits carry conditions
  // six and five when the unit is a condition source, so one flag serves both
  always_comb
  begin
    hit.chan_a = chan_a_hit_i;
    hit.chan_b = chan_b_hit_i;
    hit.cond1  = cond_hit_i[0];
    hit.cond2  = cond_hit_i[1];
    hit.cond3  = cond_hit_i[2];
    hit.cond4  = cond_hit_i[3];
  end

  // next flag value; a hit in the same cycle as the break wins, so the
  // event that coincides with the clear is not lost
  always_comb
  begin
    if (break_taken_i)
    begin
      match_d = '0;
    end
    else
    begin
      match_d = match_q;
    end
    match_d = match_d | hit;
  end

  // flags are only ever read by the host, so reading never disturbs them
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      match_q <= '0;
    end
    else
    begin
      match_q <= match_d;
    end
  end

  // ==========================================================================
  // sequential flags
  // first channel: high while a has matched and b has not; tracks the
  // next flag values so a and b hitting together leave it low
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      seq_q.chan_a <= 1'b0;
    end
    else
    begin
      seq_q.chan_a <= ubu_seq & match_d.chan_a & ~match_d.chan_b;
    end
  end

  // condition four of the 4-3-2-1 chain: a fresh hit on four always sets,
  // a hit on three clears, a break clears; four beats three if both hit
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      seq_q.cond4 <= 1'b0;
    end
    else if (!chain4)
    begin
      seq_q.cond4 <= 1'b0; // chain not selected
    end
    else if (hit.cond4)
    begin
      seq_q.cond4 <= 1'b1;
    end
    else if (hit.cond3 | break_taken_i)
    begin
      seq_q.cond4 <= 1'b0;
    end
  end

  assign match_o = match_q;
  assign seq_o   = seq_q;

  // ==========================================================================
  // interrupt events
  // an event is a flag going from clear to set, plus the break itself
  assign evt = {break_taken_i, match_d & ~match_q};

  // sticky status; set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stat_q <= '0;
    end
    else
    begin
      stat_q <= (stat_q & ~w1c) | evt;
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // ==========================================================================
  // axi4-lite write channel
  // address and data are taken independently; one write at a time
  assign s_awready_o = ~aw_got_q & ~bvalid_q;
  assign s_wready_o  = ~w_got_q & ~bvalid_q;
  assign wr_fire     = aw_got_q & w_got_q & ~bvalid_q;

  // capture of the write address
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_got_q <= 1'b0;
      awaddr_q <= 8'h00;
    end
    else if (s_awvalid_i & s_awready_o)
    begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_awaddr_i;
    end
    else if (wr_fire)
    begin
      aw_got_q <= 1'b0;
    end
  end

  // capture of the write data and strobes
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      w_got_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else if (s_wvalid_i & s_wready_o)
    begin
      w_got_q <= 1'b1;
      wdata_q <= s_wdata_i;
      wstrb_q <= s_wstrb_i;
    end
    else if (wr_fire)
    begin
      w_got_q <= 1'b0;
    end
  end

  // clear mask for the status register, only with byte lane zero
  always_comb
  begin
    w1c = '0;
    if (wr_fire && wstrb_q[0] && awaddr_q == break_flags_pkg::IRQ_STAT_OFS)
    begin
      w1c = wdata_q[break_flags_pkg::EVT_WIDTH-1:0];
    end
  end

  // control and mask registers; all live bits sit in byte lane zero
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_q <= break_flags_pkg::CTRL_RST;
      mask_q <= break_flags_pkg::IRQ_MASK_RST;
    end
    else if (wr_fire && wstrb_q[0])
    begin
      if (awaddr_q == break_flags_pkg::CTRL_OFS)
      begin
        ctrl_q <= wdata_q[break_flags_pkg::CTRL_WIDTH-1:0];
      end
      if (awaddr_q == break_flags_pkg::IRQ_MASK_OFS)
      begin
        mask_q <= wdata_q[break_flags_pkg::EVT_WIDTH-1:0];
      end
    end
  end

  // write response; flag registers are read-only, writes ignored with okay,
  // unmapped offsets answer slverr
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= break_flags_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      case (awaddr_q)
        break_flags_pkg::MATCH_OFS,
        break_flags_pkg::SEQ_OFS,
        break_flags_pkg::CTRL_OFS,
        break_flags_pkg::IRQ_STAT_OFS,
        break_flags_pkg::IRQ_MASK_OFS: bresp_q <= break_flags_pkg::RESP_OKAY;
        default:                       bresp_q <= break_flags_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_bready_i)
    begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_bvalid_o = bvalid_q;
  assign s_bresp_o  = bresp_q;

  // ==========================================================================
  // axi4-lite read channel
  // read decode; reads have no side effect on any flag
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_araddr_i)
      break_flags_pkg::MATCH_OFS:    rd_val[5:0] = match_q;
      break_flags_pkg::SEQ_OFS:      rd_val[1:0] = seq_q;
      break_flags_pkg::CTRL_OFS:     rd_val[break_flags_pkg::CTRL_WIDTH-1:0] = ctrl_q;
      break_flags_pkg::IRQ_STAT_OFS: rd_val[break_flags_pkg::EVT_WIDTH-1:0] = stat_q;
      break_flags_pkg::IRQ_MASK_OFS: rd_val[break_flags_pkg::EVT_WIDTH-1:0] = mask_q;
      default:                       rd_hit = 1'b0;
    endcase
  end

  // ready whenever no read data waits; one read at a time
  assign s_arready_o = ~rvalid_q;

  // read data register
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= break_flags_pkg::RESP_OKAY;
    end
    else if (s_arvalid_i & s_arready_o)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_hit ? break_flags_pkg::RESP_OKAY : break_flags_pkg::RESP_SLVERR;
    end
    else if (s_rready_i)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_rvalid_o = rvalid_q;
  assign s_rdata_o  = rdata_q;
  assign s_rresp_o  = rresp_q;

  // ubu_as_cond only relabels the channel bits; the logic is identical,
  // so it is kept for software to read back and steers nothing else
  logic unused_ok;
  assign unused_ok = ubu_as_cond;

endmodule : break_condition_match_flags

//--- src/break_flags_pkg.sv
// package of offsets, field positions and types for the break match flag block
package break_flags_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] MATCH_OFS     = 8'h00; // condition match flags
  localparam logic [7:0] SEQ_OFS       = 8'h04; // sequential break flags
  localparam logic [7:0] CTRL_OFS      = 8'h08; // mode control
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h0c; // sticky events, write one to clear
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h10; // event enables

  // ==========================================================================
  // control field positions
  localparam int UBU_AS_COND_BIT = 0; // user break unit feeds conditions 5 and 6
  localparam int UBU_SEQ_BIT     = 1; // user break unit sequential mode
  localparam int CHAIN4_BIT      = 2; // four-stage chain 4-3-2-1 selected
  localparam int CTRL_WIDTH      = 3; // implemented control bits

  // sequential register field positions
  localparam int SEQ_A_BIT       = 0; // channel a matched, b not yet
  localparam int SEQ_C4_BIT      = 1; // condition four pending on three

  // event field positions (bits 0..5 follow the match flag layout)
  localparam int EVT_BREAK_BIT   = 6; // a break cleared the flags
  localparam int EVT_WIDTH       = 7; // implemented event bits

  // ==========================================================================
  // reset values
  localparam logic [CTRL_WIDTH-1:0] CTRL_RST     = 3'h0;
  localparam logic [EVT_WIDTH-1:0]  IRQ_MASK_RST = 7'h00;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // match flag layout, listed high bit first; chan_a is bit 0 on the bus
  typedef struct packed {
    logic cond4; // condition_four_match
    logic cond3; // condition_three_match
    logic cond2; // condition_two_match
    logic cond1; // condition_one_match
    logic chan_b; // second channel, also condition five
    logic chan_a; // first channel, also condition six
  } match_flags_s;

  // sequential flag layout
  typedef struct packed {
    logic cond4; // condition four sequential flag
    logic chan_a; // first channel sequential flag
  } seq_flags_s;

endpackage : break_flags_pkg

//--- verif/break_flags_assertions.sv
// concurrent checks on the break match flag block ports
module break_flags_assertions
(
  input wire logic       clk_i,         // processor clock
  input wire logic       nrst_i,        // async reset, active low
  input wire logic       chan_a_hit_i,  // first channel hit
  input wire logic       chan_b_hit_i,  // second channel hit
  input wire logic [3:0] cond_hit_i,    // condition hits
  input wire logic       break_taken_i, // break occurred
  input wire logic [5:0] match_o,       // match flags
  input wire logic [1:0] seq_o,         // sequential flags
  input wire logic       s_bvalid_o,    // write response valid
  input wire logic       s_bready_i     // write response ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // single clock domain, reset masks every check
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  chan_a_set_a: assert property (chan_a_hit_i |=> match_o[0])
    else $error("first channel flag missed");
  chan_b_set_a: assert property (chan_b_hit_i |=> match_o[1])
    else $error("second channel flag missed");
  cond_set_a: assert property (|cond_hit_i |=> &(match_o[5:2] | ~$past(cond_hit_i)))
    else $error("condition flag missed");
  break_clr_a: assert property (
    break_taken_i && !chan_a_hit_i && !chan_b_hit_i && cond_hit_i == 4'h0 |=> match_o == 6'h00)
    else $error("break left a flag set");
  flag_hold_a: assert property (!break_taken_i |=> &(match_o | ~$past(match_o)))
    else $error("flag dropped without break");
  seq_chan_a: assert property (seq_o[0] |-> match_o[0] && !match_o[1])
    else $error("channel sequential flag wrong");
  seq_c4_flag_a: assert property (seq_o[1] |-> match_o[5])
    else $error("chain flag without condition four");
  seq_c4_clr_a: assert property (cond_hit_i[2] && !cond_hit_i[3] |=> !seq_o[1])
    else $error("chain flag kept after condition three");
  seq_c4_set_a: assert property ($rose(seq_o[1]) |-> $past(cond_hit_i[3]))
    else $error("chain flag rose without condition four");
  resp_done_a: assert property (s_bvalid_o && s_bready_i |=> !s_bvalid_o)
    else $error("write response repeated");
endmodule : break_flags_assertions

bind break_condition_match_flags break_flags_assertions flag_checks (
  .clk_i(clk_i), .nrst_i(nrst_i), .chan_a_hit_i(chan_a_hit_i),
  .chan_b_hit_i(chan_b_hit_i), .cond_hit_i(cond_hit_i), .break_taken_i(break_taken_i),
  .match_o(match_o), .seq_o(seq_o), .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i)
);

//--- verif/cond_comparators.sv
// comparator model producing one-cycle hit pulses
module cond_comparators
(
  input  wire logic       clk_i,  // processor clock
  input  wire logic [6:0] fire_i, // events asked for by the bench
  output logic      [6:0] hit_o   // registered hit pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] q = 7'h00; // known at time zero
  // real comparators report one clock after the access
  always @(posedge clk_i)
  begin
    q <= fire_i;
  end
  assign hit_o = q;
endmodule : cond_comparators

//--- verif/testbench.sv
// self-checking bench for the break condition match flag block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // stimulus and observed signals
  logic        clk_i   = 1'b0;
  logic        nrst_i  = 1'b0;
  logic [6:0]  fire    = 7'h00; // match layout, bit 6 is break
  logic [6:0]  hits;            // comparator pulses
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, seq, r;
  logic [31:0] rdata, d;
  logic [5:0]  match, e;
  int          fail_count      = 0;
  int          samples_checked = 0;
  // mode, event and sequential flag per step
  logic [2:0]  t_ctrl [6] = '{3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4};
  logic [6:0]  t_ev   [6] = '{7'h01, 7'h02, 7'h20, 7'h10, 7'h20, 7'h40};
  logic [1:0]  t_seq  [6] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0};

  initial forever #5 clk_i = ~clk_i;

  cond_comparators cmp (.clk_i(clk_i), .fire_i(fire), .hit_o(hits));

  // full word writes only, byte lanes not under test
  break_condition_match_flags uut (
    .clk_i(clk_i), .nrst_i(nrst_i), .chan_a_hit_i(hits[0]), .chan_b_hit_i(hits[1]),
    .cond_hit_i(hits[5:2]), .break_taken_i(hits[6]), .match_o(match), .seq_o(seq),
    .irq_o(irq), .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
    .s_wdata_i(wdata), .s_wstrb_i(4'hf), .s_wvalid_i(wvalid), .s_wready_o(wready),
    .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready), .s_araddr_i(araddr),
    .s_arvalid_i(arvalid), .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp),
    .s_rvalid_o(rvalid), .s_rready_i(rready));

  // ==========================================================================
  // helpers
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", n, exp, got);
      fail_count++;
    end
  endtask : chk

  // address and data offered together, response held until seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    s = bresp;
    bready <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      give_verdict();
    end
    // one idle edge so a following call never re-drives bready in this step
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] s);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    q = rdata;
    s = rresp;
    rready <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      give_verdict();
    end
    // one idle edge so a following call never re-drives rready in this step
    @(posedge clk_i);
  endtask : rd

  // one event pulse, then time for the flags to land
  task automatic hit(input logic [6:0] v);
    fire <= v;
    @(posedge clk_i);
    fire <= 7'h00;
    repeat (2) @(posedge clk_i);
  endtask : hit

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd(break_flags_pkg::SEQ_OFS, d, r);
    chk("seq", d, 32'h0);
    rd(break_flags_pkg::IRQ_MASK_OFS, d, r);
    chk("mask", d, 32'h0);
    $display("test reset done");
    // every event sets its flag, earlier flags stay
    e = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      hit(7'h01 << i);
      e[i] = 1'b1;
      rd(break_flags_pkg::MATCH_OFS, d, r);
      chk("match", d, {26'h0, e});
      chk("pins", {26'h0, match}, {26'h0, e});
    end
    // flags are read-only to the host
    wr(break_flags_pkg::MATCH_OFS, 32'h0, r);
    rd(break_flags_pkg::MATCH_OFS, d, r);
    chk("match ro", d, 32'h3f);
    $display("test flags done");
    // break event raises the interrupt and clears flags
    wr(break_flags_pkg::IRQ_MASK_OFS, 32'h40, r);
    chk("irq", {31'h0, irq}, 32'h0);
    hit(7'h40);
    chk("match", {26'h0, match}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(break_flags_pkg::IRQ_STAT_OFS, d, r);
    chk("stat", d, 32'h7f);
    wr(break_flags_pkg::IRQ_STAT_OFS, 32'h7f, r);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(break_flags_pkg::IRQ_STAT_OFS, d, r);
    chk("stat clr", d, 32'h0);
    $display("test break done");
    // unit in sequential mode as conditions five and six, then the four-stage chain
    e = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      wr(break_flags_pkg::CTRL_OFS, {29'h0, t_ctrl[i]}, r);
      rd(break_flags_pkg::CTRL_OFS, d, r);
      chk("ctrl", d, {29'h0, t_ctrl[i]});
      hit(t_ev[i]);
      e = t_ev[i][6] ? 6'h00 : (e | t_ev[i][5:0]);
      rd(break_flags_pkg::SEQ_OFS, d, r);
      chk("seq", d, {30'h0, t_seq[i]});
      chk("seq pins", {30'h0, seq}, {30'h0, t_seq[i]});
      rd(break_flags_pkg::MATCH_OFS, d, r);
      chk("match", d, {26'h0, e});
    end
    $display("test sequential done");
    // unmapped place is refused
    rd(8'h20, d, r);
    chk("rd resp", {30'h0, r}, {30'h0, break_flags_pkg::RESP_SLVERR});
    wr(8'h20, 32'h7, r);
    chk("wr resp", {30'h0, r}, {30'h0, break_flags_pkg::RESP_SLVERR});
    $display("test unmapped done");
    give_verdict();
  end
endmodule : testbench
